// >>> design/bpb_guard_defs.svh
// Offsets, fields, reset values and timing of the block guard logic
`ifndef BPB_GUARD_DEFS_SVH
`define BPB_GUARD_DEFS_SVH
`define BPB_CLK_NS 10
`define BPB_PROG_NS 200000
`define BPB_ERASE_NS 45000000
`define BPB_ACCESS_NS 80
`define BPB_PROG_CYC ((`BPB_PROG_NS + `BPB_CLK_NS - 1) / `BPB_CLK_NS)
`define BPB_ERASE_CYC ((`BPB_ERASE_NS + `BPB_CLK_NS - 1) / `BPB_CLK_NS)
`define BPB_ACCESS_CYC ((`BPB_ACCESS_NS + `BPB_CLK_NS - 1) / `BPB_CLK_NS)
`define BPB_OFF_CMD 32'h0000_0000
`define BPB_OFF_ADDR 32'h0000_0004
`define BPB_OFF_DATA 32'h0000_0008
`define BPB_OFF_STATUS 32'h0000_000C
`define BPB_OFF_INTSTAT 32'h0000_0010
`define BPB_OFF_INTMASK 32'h0000_0014
`define BPB_GRP_LSB 18
`define BPB_GRP_MSB 26
`define BPB_ADDR_MSB 26
`define BPB_ST_BUSY 0
`define BPB_ST_FAIL 1
`define BPB_ST_RBIT 2
`define BPB_ST_FREEZE 3
`define BPB_ST_RVALID 4
`define BPB_INT_DONE 0
`define BPB_INT_FAIL 1
`define BPB_INT_DENY 2
`define BPB_INT_W 3
`define BPB_VOL_RST 1'b1
`define BPB_NV_ERASED 1'b1
`define BPB_FREEZE_RST 1'b1
`endif

// >>> design/bpb_pkg.sv
// Types of the block guard logic
`default_nettype none
package bpb_pkg;
   typedef enum logic [2:0] {
      BPB_IDLE = 3'b000,
      BPB_PROG = 3'b001,
      BPB_PRE = 3'b010,
      BPB_VERIFY = 3'b011,
      BPB_ERASE = 3'b100,
      BPB_READ = 3'b101
   } bpb_state_t;
   typedef enum logic [2:0] {
      BPB_OP_NONE = 3'b000,
      BPB_OP_PROG_NV = 3'b001,
      BPB_OP_ERASE_NV = 3'b010,
      BPB_OP_READ_NV = 3'b011,
      BPB_OP_WRITE_VOL = 3'b100,
      BPB_OP_READ_VOL = 3'b101,
      BPB_OP_FREEZE = 3'b110
   } bpb_op_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [26:0] addr;
   } bpb_arr_req_t;
   typedef struct packed {
      logic grant;
      logic deny;
   } bpb_arr_resp_t;
endpackage : bpb_pkg
`default_nettype wire

// >>> design/bpb_guard.sv
// Per-block guard bits, guard command engine and APB register slave
//
// Behaviour
// (RULE1) 512 groups of 64 4KB sectors
// (RULE2) One non-volatile guard bit per group
// (RULE3) Program singly, erase only all together
// (RULE4) Program gives 0, erase gives 1
// (RULE5) Erase preprograms and verifies internally
// (RULE6) Program page time, erase sector time
// (RULE7) Busy shown in status while working
// (RULE8) Guard read takes initial access time
// (RULE9) No array reads during guard program
// (RULE10) Host sends group base, high bits zero
// (RULE11) Erase needs no address
// (RULE12) Read command returns guard bit state
// (RULE13) Non-volatile bits start erased at one
// (RULE14) One volatile guard bit per group
// (RULE15) Volatile write: 0 protects, 1 unprotects
// (RULE16) Volatile bit matters only when non-volatile one
// (RULE17) Freeze at 0 fails guard program/erase
// (RULE18) Reset returns volatile bits to unprotected
// (RULE19) Either bit 0 rejects array writes
`timescale 1ns/10ps
`default_nettype none
`include "bpb_guard_defs.svh"

module bpb_guard #(
   parameter int GROUPS = 512,
   parameter logic [31:0] PROG_CYC = `BPB_PROG_CYC,
   parameter logic [31:0] ERASE_CYC = `BPB_ERASE_CYC,
   parameter logic [31:0] ACCESS_CYC = `BPB_ACCESS_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire bpb_pkg::bpb_arr_req_t arrReq,
   output bpb_pkg::bpb_arr_resp_t arrResp,
   output logic irq
);
   import bpb_pkg::*;

   bpb_state_t state;
   bpb_state_t next_state;
   bpb_op_t op;
   bpb_op_t next_op;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [GROUPS-1:0] nvGuard;
   logic [GROUPS-1:0] next_nvGuard;
   logic [GROUPS-1:0] volGuard;
   logic [GROUPS-1:0] next_volGuard;
   logic freeze;
   logic next_freeze;
   logic fail;
   logic next_fail;
   logic readBit;
   logic next_readBit;
   logic readValid;
   logic next_readValid;
   logic [`BPB_ADDR_MSB:0] cmdAddr;
   logic [`BPB_ADDR_MSB:0] next_cmdAddr;
   logic cmdData;
   logic next_cmdData;
   logic [`BPB_INT_W-1:0] intStat;
   logic [`BPB_INT_W-1:0] next_intStat;
   logic [`BPB_INT_W-1:0] intMask;
   logic [`BPB_INT_W-1:0] next_intMask;
   logic [31:0] next_prdata;
   logic [GROUPS-1:0] protectedGrp;
   logic [8:0] cmdGrp;
   logic [8:0] arrGrp;
   logic wrAcc;
   logic setup;
   logic badAddr;
   logic cmdStart;
   logic [`BPB_INT_W-1:0] evt;
   logic denyNow;

   // (RULE1) Group index from byte address
   // (RULE10) Host keeps low bits zero, only group bits used
   assign cmdGrp = cmdAddr[`BPB_GRP_MSB:`BPB_GRP_LSB];
   assign arrGrp = arrReq.addr[`BPB_GRP_MSB:`BPB_GRP_LSB];

   // (RULE16) Volatile bit only counts when nv erased
   // (RULE19) Protected when either bit is 0
   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : gProt
         assign protectedGrp[g] = ~nvGuard[g] | ~volGuard[g];
      end
   endgenerate

   // Reads stay open during erase; only program blocks them
   // (RULE9) Array blocked while programming a guard bit
   // (RULE19) Writes to guarded groups rejected
   assign denyNow = arrReq.valid &
      ((state == BPB_PROG) | (arrReq.write & protectedGrp[arrGrp]));
   assign arrResp.deny = denyNow;
   assign arrResp.grant = arrReq.valid & ~denyNow;

   assign setup = psel & ~penable;
   assign wrAcc = psel & penable & pwrite;
   // Zero wait: read word is ready by the access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & badAddr;
   assign irq = |(intStat & intMask);

   // Unmapped words answer pslverr and zero data
   always_comb begin
      badAddr = 1'b1;
      if (paddr == `BPB_OFF_CMD) begin
         badAddr = 1'b0;
      end else if (paddr == `BPB_OFF_ADDR) begin
         badAddr = 1'b0;
      end else if (paddr == `BPB_OFF_DATA) begin
         badAddr = 1'b0;
      end else if (paddr == `BPB_OFF_STATUS) begin
         badAddr = 1'b0;
      end else if (paddr == `BPB_OFF_INTSTAT) begin
         badAddr = 1'b0;
      end else if (paddr == `BPB_OFF_INTMASK) begin
         badAddr = 1'b0;
      end
   end

   // Commands written while busy are dropped
   assign cmdStart = wrAcc & (paddr == `BPB_OFF_CMD) & (state == BPB_IDLE);

   // Read data captured in setup so it is stable in access
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (setup & ~pwrite) begin
         if (paddr == `BPB_OFF_CMD) begin
            next_prdata = {29'h0000_0000, op};
         end else if (paddr == `BPB_OFF_ADDR) begin
            next_prdata = {5'h00, cmdAddr};
         end else if (paddr == `BPB_OFF_DATA) begin
            next_prdata = {31'h0000_0000, cmdData};
         end else if (paddr == `BPB_OFF_STATUS) begin
            // (RULE7) Busy bit polled by host
            next_prdata[`BPB_ST_BUSY] = (state != BPB_IDLE);
            next_prdata[`BPB_ST_FAIL] = fail;
            next_prdata[`BPB_ST_RBIT] = readBit;
            next_prdata[`BPB_ST_FREEZE] = freeze;
            next_prdata[`BPB_ST_RVALID] = readValid;
         end else if (paddr == `BPB_OFF_INTSTAT) begin
            next_prdata = {29'h0000_0000, intStat};
         end else if (paddr == `BPB_OFF_INTMASK) begin
            next_prdata = {29'h0000_0000, intMask};
         end
      end
   end

   // Command engine: one command at a time, busy until done
   always_comb begin
      next_state = state;
      next_op = op;
      next_cnt = cnt;
      next_nvGuard = nvGuard;
      next_volGuard = volGuard;
      next_fail = fail;
      next_readBit = readBit;
      next_readValid = readValid;
      evt = 3'h0;
      if (denyNow) begin
         evt[`BPB_INT_DENY] = 1'b1;
      end
      case (state)
         BPB_IDLE: begin
            if (cmdStart) begin
               next_op = bpb_op_t'(pwdata[2:0]);
               next_cnt = 32'h0000_0000;
               next_fail = 1'b0;
               case (bpb_op_t'(pwdata[2:0]))
                  BPB_OP_PROG_NV: begin
                     // (RULE17) Frozen guards refuse change
                     if (!freeze) begin
                        next_fail = 1'b1;
                        evt[`BPB_INT_FAIL] = 1'b1;
                     end else begin
                        next_state = BPB_PROG;
                     end
                  end
                  BPB_OP_ERASE_NV: begin
                     // (RULE17) Frozen guards refuse erase
                     // (RULE11) No address taken for erase
                     if (!freeze) begin
                        next_fail = 1'b1;
                        evt[`BPB_INT_FAIL] = 1'b1;
                     end else begin
                        next_state = BPB_PRE;
                     end
                  end
                  BPB_OP_READ_NV, BPB_OP_READ_VOL: begin
                     next_readValid = 1'b0;
                     next_state = BPB_READ;
                  end
                  BPB_OP_WRITE_VOL: begin
                     // (RULE14) Volatile bit rewritable whenever idle, frozen or not
                     // (RULE15) 0 protects, 1 unprotects
                     next_volGuard[cmdGrp] = cmdData;
                     evt[`BPB_INT_DONE] = 1'b1;
                  end
                  BPB_OP_FREEZE: begin
                     // Freeze bit itself falls in its own group
                     evt[`BPB_INT_DONE] = 1'b1;
                  end
                  default: begin
                     next_fail = 1'b1;
                     evt[`BPB_INT_FAIL] = 1'b1;
                  end
               endcase
            end
         end
         BPB_PROG: begin
            // (RULE6) Page program duration
            next_cnt = cnt + 32'h0000_0001;
            if (cnt == PROG_CYC - 32'h0000_0001) begin
               // (RULE3) One bit at a time
               // (RULE4) Program drives 0
               next_nvGuard[cmdGrp] = 1'b0;
               next_state = BPB_IDLE;
               evt[`BPB_INT_DONE] = 1'b1;
            end
         end
         BPB_PRE: begin
            // (RULE5) Internal preprogram before erase
            next_nvGuard = '0;
            next_state = BPB_VERIFY;
         end
         BPB_VERIFY: begin
            // (RULE5) Verify preprogram, fail if any left
            if (|nvGuard) begin
               next_fail = 1'b1;
               next_state = BPB_IDLE;
               evt[`BPB_INT_FAIL] = 1'b1;
            end else begin
               next_state = BPB_ERASE;
            end
         end
         BPB_ERASE: begin
            // (RULE6) Sector erase duration
            next_cnt = cnt + 32'h0000_0001;
            if (cnt == ERASE_CYC - 32'h0000_0001) begin
               // (RULE3) Whole set at once
               // (RULE4) Erase returns all to 1
               next_nvGuard = {GROUPS{`BPB_NV_ERASED}};
               next_state = BPB_IDLE;
               evt[`BPB_INT_DONE] = 1'b1;
            end
         end
         BPB_READ: begin
            // (RULE8) Initial access latency
            next_cnt = cnt + 32'h0000_0001;
            if (cnt == ACCESS_CYC - 32'h0000_0001) begin
               // (RULE12) Return addressed guard state
               if (op == BPB_OP_READ_NV) begin
                  next_readBit = nvGuard[cmdGrp];
               end else begin
                  next_readBit = volGuard[cmdGrp];
               end
               next_readValid = 1'b1;
               next_state = BPB_IDLE;
               evt[`BPB_INT_DONE] = 1'b1;
            end
         end
         default: begin
            next_state = BPB_IDLE;
         end
      endcase
   end

   // Guard array kept in flops; reset models a fresh part
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= BPB_IDLE;
         op <= BPB_OP_NONE;
         cnt <= 32'h0000_0000;
         // (RULE2) One nv bit per group
         // (RULE13) Delivered erased
         nvGuard <= {GROUPS{`BPB_NV_ERASED}};
         // (RULE18) Volatile bits unprotected after reset
         volGuard <= {GROUPS{`BPB_VOL_RST}};
         fail <= 1'b0;
         readBit <= 1'b0;
         readValid <= 1'b0;
      end else begin
         state <= next_state;
         op <= next_op;
         cnt <= next_cnt;
         nvGuard <= next_nvGuard;
         volGuard <= next_volGuard;
         fail <= next_fail;
         readBit <= next_readBit;
         readValid <= next_readValid;
      end
   end

   // (RULE17) Freeze falls by command only
   // No command raises it, so only reset reopens the guards
   always_comb begin
      next_freeze = freeze;
      if (cmdStart & (bpb_op_t'(pwdata[2:0]) == BPB_OP_FREEZE)) begin
         next_freeze = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         freeze <= `BPB_FREEZE_RST;
      end else begin
         freeze <= next_freeze;
      end
   end

   // Operands only move while idle, so a running command keeps its target
   always_comb begin
      next_cmdAddr = cmdAddr;
      next_cmdData = cmdData;
      next_intMask = intMask;
      next_intStat = intStat;
      if (wrAcc & (paddr == `BPB_OFF_ADDR) & (state == BPB_IDLE)) begin
         next_cmdAddr = pwdata[`BPB_ADDR_MSB:0];
      end
      if (wrAcc & (paddr == `BPB_OFF_DATA) & (state == BPB_IDLE)) begin
         next_cmdData = pwdata[0];
      end
      // Mask and clear work even while busy
      if (wrAcc & (paddr == `BPB_OFF_INTMASK)) begin
         next_intMask = pwdata[`BPB_INT_W-1:0];
      end
      if (wrAcc & (paddr == `BPB_OFF_INTSTAT)) begin
         next_intStat = intStat & ~pwdata[`BPB_INT_W-1:0];
      end
      // Set wins over a same-cycle write-one clear, so no event is lost
      next_intStat = next_intStat | evt;
   end

   // Host register group
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdAddr <= '0;
         cmdData <= 1'b0;
         intStat <= 3'h0;
         intMask <= 3'h0;
      end else begin
         cmdAddr <= next_cmdAddr;
         cmdData <= next_cmdData;
         intStat <= next_intStat;
         intMask <= next_intMask;
      end
   end

   // Read word loaded in setup, zero otherwise, so writes read back 0
   // Captured a cycle early so prdata stands through the access phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end
endmodule : bpb_guard
`default_nettype wire

// >>> tb/bpb_guard_props.sv
// Port checker of the block guard
`timescale 1ns/10ps
`default_nettype none
module bpb_guard_props #(
   parameter logic [31:0] PROG_CYC = 32'h14,
   parameter logic [31:0] ERASE_CYC = 32'h32,
   parameter logic [31:0] ACCESS_CYC = 32'h8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire bpb_pkg::bpb_arr_req_t arrReq,
   input wire bpb_pkg::bpb_arr_resp_t arrResp
);
   logic [31:0] left, next_left;
   logic prog, next_prog, frz, next_frz, used, next_used, cmdWr, stRd;
   // Commands while busy are dropped, as the engine does
   assign cmdWr = psel & penable & pwrite & (paddr == 32'h0) & (left == 32'h0);
   assign stRd = psel & penable & ~pwrite & (paddr == 32'hC);
   always_comb begin
      next_left = (left != 32'h0) ? left - 32'h1 : left;
      next_prog = prog & (left > 32'h1);
      next_frz = frz;
      next_used = used;
      if (cmdWr) begin
         case (pwdata[2:0])
            3'h1: begin
               next_left = frz ? PROG_CYC : 32'h0;
               next_prog = frz;
               next_used = 1'b1;
            end
            3'h2: begin
               next_left = frz ? ERASE_CYC + 32'h2 : 32'h0;
               next_used = 1'b1;
            end
            3'h3, 3'h5: next_left = ACCESS_CYC;
            3'h4: next_used = 1'b1;
            3'h6: next_frz = 1'b0;
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         left <= 32'h0;
         prog <= 1'b0;
         frz <= 1'b1;
         used <= 1'b0;
      end else begin
         left <= next_left;
         prog <= next_prog;
         frz <= next_frz;
         used <= next_used;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_prog_denies: assert property (
      prog && left > 32'h1 && arrReq.valid |-> arrResp.deny) else $error("array access granted in guard program");
   a_read_granted: assert property (
      !prog && arrReq.valid && !arrReq.write |-> arrResp.grant) else $error("array read refused outside program");
   a_one_answer: assert property (
      arrReq.valid |-> arrResp.grant != arrResp.deny) else $error("grant and deny disagree");
   a_reset_open: assert property (
      !used && arrReq.valid |-> arrResp.grant) else $error("group protected without any guard command");
   a_status_busy: assert property (
      stRd && $past(left) > 32'h1 |-> prdata[0]) else $error("busy missing during guard operation");
   a_status_idle: assert property (
      stRd && $past(left) == 32'h0 |-> !prdata[0]) else $error("busy shown while idle");
   a_freeze_shown: assert property (
      stRd |-> prdata[3] == $past(frz)) else $error("freeze bit wrong in status");
   a_zero_wait: assert property (
      psel && penable |-> pready) else $error("wait state inserted");
   a_unmapped_err: assert property (
      psel && penable && paddr > 32'h14 |-> pslverr && prdata == 32'h0) else $error("unmapped access not flagged");
endmodule : bpb_guard_props
bind bpb_guard bpb_guard_props #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC), .ACCESS_CYC(ACCESS_CYC)) u_props (
   .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .arrReq(arrReq), .arrResp(arrResp));
`default_nettype wire

// >>> tb/bpb_host_model.sv
// Register bus host in place of the command side
`timescale 1ns/10ps
`default_nettype none
module bpb_host_model (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end
   function automatic logic [31:0] grpBase(input logic [8:0] g);
      return {5'h00, g, 18'h00000};
   endfunction : grpBase
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Request held until the edge that samples pready high
      do @(posedge clk); while (!(pready === 1'b1 && psel === 1'b1 && penable === 1'b1));
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next request never lands in this time step
      @(posedge clk);
   endtask : xfer
endmodule : bpb_host_model
`default_nettype wire

// >>> tb/test_block_protection_bits_256k.sv
// Self-checking bench of the block guard
`timescale 1ns/10ps
`default_nettype none
`include "bpb_guard_defs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_block_protection_bits_256k;
   import bpb_pkg::*;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [31:0] paddr, pwdata, prdata, v;
   logic [8:0] g, h;
   bpb_arr_req_t arrReq;
   bpb_arr_resp_t arrResp;
   int fails = 0;
   int n_compared = 0;
   int seed = 32'h4FC1AD3B;
   bpb_guard #(.PROG_CYC(32'h14), .ERASE_CYC(32'h32)) dut (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .arrReq(arrReq), .arrResp(arrResp), .irq(irq));
   bpb_host_model u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic print_verdict;
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict();
   end
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, v, er);
   endtask : wr
   task automatic rd(input logic [31:0] a);
      u_host.xfer(1'b0, a, 32'h0, v, er);
   endtask : rd
   // Leaves the final status word in v
   task automatic cmd(input logic [2:0] op);
      wr(`BPB_OFF_CMD, {29'h0, op});
      do rd(`BPB_OFF_STATUS); while (v[`BPB_ST_BUSY] !== 1'b0);
   endtask : cmd
   function automatic logic expDeny(input logic w, input logic nv, input logic vol);
      return w & ~(nv & vol);
   endfunction : expDeny
   task automatic arr(input logic w, input logic [8:0] x, input logic exp);
      arrReq <= '{1'b1, w, {x, 18'($random(seed))}};
      @(negedge clk);
      `CHK(arrResp.deny, exp)
      `CHK(arrResp.grant, ~exp)
      @(posedge clk);
      arrReq <= '0;
      @(posedge clk);
   endtask : arr
   initial begin
      reset_n = 1'b0;
      arrReq = '0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      arr(1'b1, 9'h1FF, 1'b0);
      rd(32'h18);
      `CHK({er, v}, 33'h100000000)
      wr(`BPB_OFF_INTMASK, 32'h1);
      for (int i = 0; i < 3; i++) begin
         g = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
         h = g ^ 9'h001;
         wr(`BPB_OFF_ADDR, u_host.grpBase(g));
         cmd(3'h5);
         `CHK(v[`BPB_ST_RBIT], 1'b1)
         cmd(3'h3);
         `CHK(v[`BPB_ST_RBIT], 1'b1)
         `CHK(v[`BPB_ST_RVALID], 1'b1)
         wr(`BPB_OFF_DATA, 32'h0);
         cmd(3'h4);
         arr(1'b1, g, expDeny(1'b1, 1'b1, 1'b0));
         arr(1'b0, g, 1'b0);
         arr(1'b1, h, 1'b0);
         wr(`BPB_OFF_DATA, 32'h1);
         cmd(3'h4);
         arr(1'b1, g, 1'b0);
         wr(`BPB_OFF_INTSTAT, 32'h7);
         wr(`BPB_OFF_CMD, 32'h1);
         arr(1'b0, h, 1'b1);
         rd(`BPB_OFF_INTSTAT);
         `CHK(v[`BPB_INT_DENY], 1'b1)
         cmd(3'h0);
         @(negedge clk);
         `CHK(irq, 1'b1)
         wr(`BPB_OFF_INTSTAT, 32'h7);
         @(negedge clk);
         `CHK(irq, 1'b0)
         cmd(3'h3);
         `CHK(v[`BPB_ST_RBIT], 1'b0)
         arr(1'b1, g, expDeny(1'b1, 1'b0, 1'b1));
         wr(`BPB_OFF_ADDR, u_host.grpBase(h));
         cmd(3'h3);
         `CHK(v[`BPB_ST_RBIT], 1'b1)
         cmd(3'h2);
         wr(`BPB_OFF_ADDR, u_host.grpBase(g));
         cmd(3'h3);
         `CHK(v[`BPB_ST_RBIT], 1'b1)
      end
      wr(`BPB_OFF_INTMASK, 32'h0);
      @(negedge clk);
      `CHK(irq, 1'b0)
      cmd(3'h6);
      `CHK(v[`BPB_ST_FREEZE], 1'b0)
      cmd(3'h1);
      `CHK(v[`BPB_ST_FAIL], 1'b1)
      rd(`BPB_OFF_INTSTAT);
      `CHK(v[`BPB_INT_FAIL], 1'b1)
      cmd(3'h2);
      `CHK(v[`BPB_ST_FAIL], 1'b1)
      cmd(3'h7);
      `CHK(v[`BPB_ST_FAIL], 1'b1)
      cmd(3'h3);
      `CHK(v[`BPB_ST_RBIT], 1'b1)
      wr(`BPB_OFF_DATA, 32'h0);
      cmd(3'h4);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      arr(1'b1, g, 1'b0);
      wr(`BPB_OFF_ADDR, u_host.grpBase(g));
      cmd(3'h5);
      `CHK(v[`BPB_ST_RBIT], 1'b1)
      rd(`BPB_OFF_STATUS);
      `CHK(v[`BPB_ST_FREEZE], 1'b1)
      print_verdict();
   end
endmodule : test_block_protection_bits_256k
`default_nettype wire
